// ### src/gpio_port.sv
// Purpose: General digital I/O port bank with an AHB-Lite register slave.
// Assumes: hclk at 20 MHz; single word transfers; pads joined outside.
// Notes:   Zero wait states; read data is taken from next-state values so
//          a read right after a write sees the written word.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_defines.svh"

module gpio_port #(
  parameter int WIDTH = `GPIO_PORT_WIDTH
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pads
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe,
  output logic [WIDTH-1:0] pullup_en
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] direction_reg;
  logic [WIDTH-1:0] direction_next;
  logic [WIDTH-1:0] output_reg;
  logic [WIDTH-1:0] output_next;
  logic [1:0] port_ctrl_reg;
  logic [1:0] port_ctrl_next;
  logic mcu_pud_reg;
  logic mcu_pud_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;

  // Data-phase bookkeeping
  logic dp_valid_reg;
  logic dp_write_reg;
  gpio_pkg::gpio_reg_sel_t dp_sel_reg;

  // Per-pin status from the cells
  logic [WIDTH-1:0] in_bits;
  logic [WIDTH-1:0] in_nexts;
  logic [WIDTH-1:0] bbm_holds;
  logic [WIDTH-1:0] pullups;

  // Decode results
  gpio_pkg::gpio_reg_sel_t ap_sel;
  gpio_pkg::gpio_reg_sel_t rd_sel;
  logic ap_take;
  logic ap_word;
  logic wr_en;
  logic wr_input;
  logic wr_direction;
  logic wr_output;
  logic wr_port_ctrl;
  logic wr_mcu_ctrl;
  logic rd_take;

  // Effective controls
  logic bbm_en;
  logic pud_any;
  logic [WIDTH-1:0] wdata_w;
  logic [WIDTH-1:0] toggle_mask;

  // ----------------------------------------------------------------
  // Address phase
  // ----------------------------------------------------------------

  // A transfer is taken when selected, NONSEQ/SEQ and the bus is ready
  assign ap_take = hsel & htrans[1] & hready;

  // Only whole words are served; narrower sizes are ignored, still OKAY
  assign ap_word = (hsize == 3'h2) & (haddr[1:0] == 2'h0);

  // Register selection by offset; unmapped words select nothing
  always_comb begin
    if (!ap_word) begin
      ap_sel = gpio_pkg::sel_none;
    end else if (haddr[7:0] == `GPIO_OFS_INPUT) begin
      ap_sel = gpio_pkg::sel_input;
    end else if (haddr[7:0] == `GPIO_OFS_DIRECTION) begin
      ap_sel = gpio_pkg::sel_direction;
    end else if (haddr[7:0] == `GPIO_OFS_OUTPUT) begin
      ap_sel = gpio_pkg::sel_output;
    end else if (haddr[7:0] == `GPIO_OFS_PORT_CTRL) begin
      ap_sel = gpio_pkg::sel_port_ctrl;
    end else if (haddr[7:0] == `GPIO_OFS_MCU_CTRL) begin
      ap_sel = gpio_pkg::sel_mcu_ctrl;
    end else if (haddr[7:0] == `GPIO_OFS_PULLUP_STAT) begin
      ap_sel = gpio_pkg::sel_pullup_stat;
    end else if (haddr[7:0] == `GPIO_OFS_BBM_STAT) begin
      ap_sel = gpio_pkg::sel_bbm_stat;
    end else begin
      ap_sel = gpio_pkg::sel_none;
    end
  end

  // Address phase is remembered for the data phase that follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_sel_reg <= gpio_pkg::sel_none;
    end else if (hready) begin
      dp_valid_reg <= ap_take;
      dp_write_reg <= hwrite;
      dp_sel_reg <= ap_sel;
    end
  end

  // ----------------------------------------------------------------
  // Data phase write strobes
  // ----------------------------------------------------------------
  assign wr_en = dp_valid_reg & dp_write_reg;
  assign wr_input = wr_en & (dp_sel_reg == gpio_pkg::sel_input);
  assign wr_direction = wr_en & (dp_sel_reg == gpio_pkg::sel_direction);
  assign wr_output = wr_en & (dp_sel_reg == gpio_pkg::sel_output);
  assign wr_port_ctrl = wr_en & (dp_sel_reg == gpio_pkg::sel_port_ctrl);
  assign wr_mcu_ctrl = wr_en & (dp_sel_reg == gpio_pkg::sel_mcu_ctrl);
  assign wdata_w = hwdata[WIDTH-1:0];

  // Ones written to the input register flip output bits, zeros do nothing
  assign toggle_mask = wr_input ? wdata_w : '0;

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------

  // Direction is a plain read/write register
  assign direction_next = wr_direction ? wdata_w : direction_reg;

  // Output register: load on write, else toggle by the input-register write
  assign output_next = wr_output ? wdata_w : (output_reg ^ toggle_mask);

  // Port-wise break-before-make and pull-up disable
  assign port_ctrl_next = wr_port_ctrl ? hwdata[1:0] : port_ctrl_reg;

  // Global pull-up disable at its fixed bit; the rest read as zero
  assign mcu_pud_next = wr_mcu_ctrl ? hwdata[`GPIO_MCU_PUD_BIT] : mcu_pud_reg;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------

  // Everything clears on reset: all pins start as inputs, pull-ups off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      direction_reg <= `GPIO_RST_DIRECTION;
      output_reg <= `GPIO_RST_OUTPUT;
      port_ctrl_reg <= `GPIO_RST_PORT_CTRL;
      mcu_pud_reg <= `GPIO_RST_MCU_PUD;
    end else begin
      direction_reg <= direction_next;
      output_reg <= output_next;
      port_ctrl_reg <= port_ctrl_next;
      mcu_pud_reg <= mcu_pud_next;
    end
  end

  // ----------------------------------------------------------------
  // Effective port controls
  // ----------------------------------------------------------------

  // One enable covers every pin of the port at once
  assign bbm_en = port_ctrl_reg[`GPIO_PCR_BBM_BIT];

  // Either disable source removes all pull-ups of this port
  assign pud_any = mcu_pud_reg | port_ctrl_reg[`GPIO_PCR_PUD_BIT];

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  // Software must keep direction changes two cycles apart when the
  // hold is on; a faster toggle only shortens the drive, never shorts.
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      gpio_pin_cell u_cell (
        .hclk(hclk),
        .hresetn(hresetn),
        .dir_bit(direction_reg[i]),
        .out_bit(output_reg[i]),
        .pud_any(pud_any),
        .bbm_en(bbm_en),
        .pad_in(pad_in[i]),
        .pad_out(pad_out[i]),
        .pad_oe(pad_oe[i]),
        .pullup_en(pullups[i]),
        .in_bit(in_bits[i]),
        .in_next(in_nexts[i]),
        .bbm_hold(bbm_holds[i])
      );
    end
  endgenerate

  assign pullup_en = pullups;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Read select is captured only for a read in the address phase
  assign rd_take = ap_take & ~hwrite;
  assign rd_sel = rd_take ? ap_sel : gpio_pkg::sel_none;

  // Next-state register values are muxed so a write just before is already seen; the two status words are live;
  // the input register shows the value the synchroniser will load.
  always_comb begin
    hrdata_next = 32'h0000_0000;
    case (rd_sel)
      gpio_pkg::sel_input: begin
        hrdata_next[WIDTH-1:0] = in_nexts;
      end
      gpio_pkg::sel_direction: begin
        hrdata_next[WIDTH-1:0] = direction_next;
      end
      gpio_pkg::sel_output: begin
        hrdata_next[WIDTH-1:0] = output_next;
      end
      gpio_pkg::sel_port_ctrl: begin
        hrdata_next[1:0] = port_ctrl_next;
      end
      gpio_pkg::sel_mcu_ctrl: begin
        hrdata_next[`GPIO_MCU_PUD_BIT] = mcu_pud_next;
      end
      gpio_pkg::sel_pullup_stat: begin
        hrdata_next[WIDTH-1:0] = pullups;
      end
      gpio_pkg::sel_bbm_stat: begin
        hrdata_next[WIDTH-1:0] = bbm_holds;
      end
      default: begin
        hrdata_next = 32'h0000_0000;
      end
    endcase
  end

  // Read data stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (hready) begin
      hrdata_reg <= hrdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------

  // Every access completes at once and is always OKAY
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

`default_nettype wire

// ### src/gpio_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts for
//          the general digital I/O port bank.
// Assumes: 32-bit AHB-Lite register bus, one register per aligned word.
// Notes:   Definitions only; included by its bare name.
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define GPIO_OFS_INPUT 8'h00
`define GPIO_OFS_DIRECTION 8'h04
`define GPIO_OFS_OUTPUT 8'h08
`define GPIO_OFS_PORT_CTRL 8'h0C
`define GPIO_OFS_MCU_CTRL 8'h10
`define GPIO_OFS_PULLUP_STAT 8'h14
`define GPIO_OFS_BBM_STAT 8'h18

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define GPIO_PCR_BBM_BIT 0
`define GPIO_PCR_PUD_BIT 1
`define GPIO_MCU_PUD_BIT 4
`define GPIO_PORT_WIDTH 8
`define GPIO_RST_DIRECTION 8'h00
`define GPIO_RST_OUTPUT 8'h00
`define GPIO_RST_PORT_CTRL 2'h0
`define GPIO_RST_MCU_PUD 1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GPIO_CLK_PERIOD_NS 50
`define GPIO_BBM_HOLD_NS 50
`define GPIO_BBM_HOLD_CYC ((`GPIO_BBM_HOLD_NS + `GPIO_CLK_PERIOD_NS - 1) / `GPIO_CLK_PERIOD_NS)

`endif

// ### src/gpio_pkg.sv
// Purpose: Types shared by the I/O port bank.
// Assumes: Constants live in gpio_defines.svh.
// Notes:   Nothing here is imported; users write gpio_pkg::name.
package gpio_pkg;

  // ----------------------------------------------------------------
  // Register selection from the address decode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    sel_none,
    sel_input,
    sel_direction,
    sel_output,
    sel_port_ctrl,
    sel_mcu_ctrl,
    sel_pullup_stat,
    sel_bbm_stat
  } gpio_reg_sel_t;

endpackage

// ### src/gpio_pin_cell.sv
// Purpose: One pad of the port: drive enable, pull-up, break-before-make
//          hold and the latch-plus-register input synchroniser.
// Assumes: Direction and output bits come from flip-flops in the parent.
// Notes:   The latch is intentional; it gives the half-cycle input path.
`timescale 1ns/1ns
`default_nettype none

module gpio_pin_cell (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control from the register file
  input wire logic dir_bit,
  input wire logic out_bit,
  input wire logic pud_any,
  input wire logic bbm_en,
  // Pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pullup_en,
  // Status back to the register file
  output logic in_bit,
  output logic in_next,
  output logic bbm_hold
);

  logic dir_prev_reg;
  logic sync_latch;
  logic in_reg;

  // Direction seen one cycle ago, to spot an input-to-output switch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_prev_reg <= 1'b0;
    end else begin
      dir_prev_reg <= dir_bit;
    end
  end

  // Hold only on a rising direction; falling adds nothing
  assign bbm_hold = bbm_en & dir_bit & ~dir_prev_reg;

  // Reset gates the enables directly, so no clock is needed to release
  assign pad_oe = hresetn & dir_bit & ~bbm_hold;
  assign pad_out = out_bit;
  assign pullup_en = hresetn & ~dir_bit & out_bit & ~pud_any;

  // Transparent while the clock is high, holds from the falling edge
  always_latch begin
    if (hclk) begin
      sync_latch <= pad_in;
    end
  end

  // Second stage loads the latched level on the next rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_reg <= 1'b0;
    end else begin
      in_reg <= sync_latch;
    end
  end

  assign in_bit = in_reg;
  assign in_next = sync_latch;

endmodule

`default_nettype wire

// ### tb/gpio_port_sva.sv
// Purpose: Concurrent checks on the port bank's bus and pad ports.
// Assumes: Pads and bus inputs change only just after rising edges.
// Notes:   Bound into every gpio_port instance at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_defines.svh"

module gpio_port_chk #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pads
  input wire logic [WIDTH-1:0] pad_in,
  input wire logic [WIDTH-1:0] pad_out,
  input wire logic [WIDTH-1:0] pad_oe,
  input wire logic [WIDTH-1:0] pullup_en
);
  // ----------------------------------------------------------------
  // Taken transfers; pads may only move two or three edges after a write
  // ----------------------------------------------------------------
  wire logic taken = hsel & htrans[1] & hready & (hsize == 3'b010);
  wire logic wr = taken & hwrite;
  wire logic rd_in = taken & ~hwrite & (haddr[7:0] == `GPIO_OFS_INPUT);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_bus_ok; hreadyout && !hresp && (hrdata[31:WIDTH] == '0); endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not zero-wait OKAY");
  property p_rst_hiz; disable iff (1'b0) !hresetn |-> (pad_oe == '0) && (pullup_en == '0); endproperty
  a_rst_hiz: assert property (p_rst_hiz) else $error("pad active during reset");
  property p_pu_excl; (pad_oe & pullup_en) == '0; endproperty
  a_pu_excl: assert property (p_pu_excl) else $error("pull-up on a driven pin");
  property p_oe_rise; |(pad_oe & ~$past(pad_oe)) |-> $past(wr, 2) || $past(wr, 3); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive began at wrong time");
  property p_oe_fall; |(~pad_oe & $past(pad_oe)) |-> $past(wr, 2); endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("drive release delayed");
  property p_pu_chg; (pullup_en != $past(pullup_en)) |-> $past(wr, 2); endproperty
  a_pu_chg: assert property (p_pu_chg) else $error("pull-up moved without write");
  property p_out_chg; (pad_out != $past(pad_out)) |-> $past(wr, 2); endproperty
  a_out_chg: assert property (p_out_chg) else $error("drive value moved without write");
  property p_in_read; rd_in |=> hrdata[WIDTH-1:0] == $past(pad_in); endproperty
  a_in_read: assert property (p_in_read) else $error("input read not one period behind pad");
  c_hold: cover property (|(pad_oe & ~$past(pad_oe)) && $past(wr, 3) && !$past(wr, 2));
  c_read: cover property (rd_in);
  c_pu: cover property (|pullup_en);
endmodule

bind gpio_port gpio_port_chk #(.WIDTH(WIDTH)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pullup_en));
`default_nettype wire

// ### tb/gpio_pad_model.sv
// Purpose: Board side of the pads: external drivers, pull-ups, floating.
// Assumes: The port wins over a board driver on a driven pin.
// Notes:   A floating pin flips every cycle so no stale level reads true.
`timescale 1ns/1ns
`default_nettype none

module gpio_pad_model #(
  parameter int WIDTH = 8
) (
  // Clock
  input wire logic hclk,
  // From the port
  input wire logic [WIDTH-1:0] pad_out,
  input wire logic [WIDTH-1:0] pad_oe,
  input wire logic [WIDTH-1:0] pullup_en,
  // Board drivers
  input wire logic [WIDTH-1:0] ext_en,
  input wire logic [WIDTH-1:0] ext_val,
  // Level seen by the port
  output logic [WIDTH-1:0] pad_in
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // Starts at a known level so an undriven pin toggles instead of staying unknown
  logic [WIDTH-1:0] last_reg = '0;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & (pullup_en | ~last_reg));
  // Remember the level so an undriven pin shows its inverse next cycle
  always @(posedge hclk) last_reg <= pad_in;
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the port bank over AHB-Lite.
// Assumes: 20 MHz clock; zero-wait slave as handed over.
// Notes:   Reads are noted in a queue and compared by a monitor.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_defines.svh"

module tb_top;
  // ----------------------------------------------------------------
  // Signals, design and board
  // ----------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_dph;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] pad_in, pad_out, pad_oe, pullup_en, ext_en, ext_val;
  logic [31:0] exp_q[$];
  int failures, num_checks, seed;

  gpio_port #(.WIDTH(8)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pullup_en(pullup_en));
  gpio_pad_model #(.WIDTH(8)) u_pads (.hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    #500000;
    failures++;
    finish_test();
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Bounded wait for the slave's ready at a rising edge
  task automatic edge_wait;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      failures++;
      finish_test();
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    edge_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    edge_wait();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  // Note a taken read, compare in the settled low half of its data phase
  always @(posedge hclk) rd_dph <= hsel & htrans[1] & ~hwrite & hreadyout;
  always @(negedge hclk) begin
    if (rd_dph === 1'b1 && exp_q.size() > 0) check("read data", hrdata, exp_q.pop_front());
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h4860;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'b010;
    ext_en = 8'h0F;
    ext_val = 8'h00;
    repeat (10) @(posedge hclk);
    check("oe in reset", 32'(pad_oe), 32'h0);
    hresetn <= 1'b1;
    rd(`GPIO_OFS_DIRECTION, 32'h0);
    rd(`GPIO_OFS_OUTPUT, 32'h0);
    rd(`GPIO_OFS_MCU_CTRL, 32'h0);
    rd(8'h1C, 32'h0);
    $display("reset test done");
    // Output bits before direction: tri-state to drive-high goes via pull-up
    xfer(1'b1, `GPIO_OFS_OUTPUT, 32'hAA);
    @(negedge hclk);
    check("pull-ups as inputs", 32'(pullup_en), 32'hAA);
    xfer(1'b1, `GPIO_OFS_DIRECTION, 32'hF0);
    @(negedge hclk);
    check("drive enables", 32'(pad_oe), 32'hF0);
    check("drive levels", 32'(pad_out & pad_oe), 32'hA0);
    check("pull-ups mixed", 32'(pullup_en), 32'h0A);
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, i ? `GPIO_OFS_MCU_CTRL : `GPIO_OFS_PORT_CTRL, i ? 32'h10 : 32'h02);
      @(negedge hclk);
      check("pull-ups disabled", 32'(pullup_en), 32'h0);
      rd(`GPIO_OFS_PULLUP_STAT, 32'h0);
      xfer(1'b1, i ? `GPIO_OFS_MCU_CTRL : `GPIO_OFS_PORT_CTRL, 32'h0);
      @(negedge hclk);
      check("pull-ups restored", 32'(pullup_en), 32'h0A);
    end
    $display("pin config test done");
    xfer(1'b1, `GPIO_OFS_INPUT, 32'h0F);
    rd(`GPIO_OFS_OUTPUT, 32'hA5);
    xfer(1'b1, `GPIO_OFS_INPUT, 32'h00);
    rd(`GPIO_OFS_OUTPUT, 32'hA5);
    $display("toggle test done");
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      ext_val <= v[15:8];
      xfer(1'b1, `GPIO_OFS_OUTPUT, {24'h0, v[7:0]});
      rd(`GPIO_OFS_INPUT, {24'h0, (v[7:0] & 8'hF0) | (v[15:8] & 8'h0F)});
    end
    $display("read-back test done");
    xfer(1'b1, `GPIO_OFS_DIRECTION, 32'h0);
    for (int b = 1; b >= 0; b--) begin
      xfer(1'b1, `GPIO_OFS_PORT_CTRL, 32'(b));
      xfer(1'b1, `GPIO_OFS_DIRECTION, 32'hFF);
      @(negedge hclk);
      check("oe first cycle", 32'(pad_oe), b ? 32'h0 : 32'hFF);
      @(negedge hclk);
      check("oe second cycle", 32'(pad_oe), 32'hFF);
      xfer(1'b1, `GPIO_OFS_DIRECTION, 32'h0);
      @(negedge hclk);
      check("oe released", 32'(pad_oe), 32'h0);
    end
    $display("break-before-make test done");
    xfer(1'b1, `GPIO_OFS_DIRECTION, 32'hF0);
    @(posedge hclk);
    hresetn <= 1'b0;
    #1;
    check("oe under reset", 32'(pad_oe), 32'h0);
    check("pull-up under reset", 32'(pullup_en), 32'h0);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`GPIO_OFS_DIRECTION, 32'h0);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
